// ===== rtl/spiep_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spiep_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic push;
   logic pop;
   assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
   assign outValid = wrPtr != rdPtr;
   assign outData = mem[rdPtr[AW-1:0]];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr[AW-1:0]] <= inData;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else if (flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         if (push)
            wrPtr <= wrPtr + 1'b1;
         if (pop)
            rdPtr <= rdPtr + 1'b1;
      end
   end
endmodule : spiep_fifo
`default_nettype wire

// ===== rtl/spiep_front.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: chip select high and no write cycle gives standby; low means active.
// RULE2: works in mode 0 or 3, sample on rising, drive on falling.
// RULE3: master parks clock low in mode 0, high in mode 3.
// RULE4: pause starts only with hold low while clock is low.
// RULE5: during pause output floats, input and clock ignored.
// RULE6: pause ends when hold high while clock low, or clock then falls.
// RULE7: deselect during pause abandons the transfer. The code still executes a write that is paused on a data byte boundary.
// RULE8: after power-up, only a chip select falling edge selects.
// RULE9: writes need latch set and select low throughout.
// RULE10: writes are whole bytes with at least one data byte.
// RULE11: writes start only when select rises on a data byte boundary.
// RULE12: reads keep shifting data until select rises.
// RULE13: status layout b7 disable, b3 b2 protect, b1 latch, b0 busy.
// RULE14: busy set from accepted write decode until write cycle ends.
// RULE15: latch clear means writes decoded but not executed.
// RULE16: set-enable sets latch; clear-enable, write completion, power-up clear it.
// RULE17: protect bits non-volatile, written only by unprotected status write. The code reloads them from BP_RESET on reset.
// RULE18: protect codes 00 none, 01 upper quarter, 10 half, 11 all plus id.
// RULE19: disable bit zero allows status writes regardless of pin.
// RULE20: disable one and pin low discards status writes.
// RULE21: frozen state entered either order, left only by pin high.
// RULE22: output changes after falling edge, msb first, floats otherwise.
// RULE23: status write refused while a write cycle runs.
module spiep_front #(
   parameter int WRITE_CYCLES = spiep_pkg::WRITE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // spi pins
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic serialIn,
   input wire logic hold_n,
   input wire logic writeProtect_n,
   output logic serialOut,
   output logic serialOutEn,
   // array side
   output logic memWrValid,
   input wire logic memWrReady,
   output logic [7:0] memWrData,
   output logic [15:0] memAddr,
   output logic memIdPage,
   output logic memCommit,
   input wire logic [7:0] memRdData,
   // state
   output logic standby,
   output logic [7:0] statusProtectionRegister
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   logic sclkPrev;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // select reads low out of reset so a select already low at power-up is no falling edge
         pinMeta <= 5'h1C;
         pinSync <= 5'h1C;
         sclkPrev <= 1'b0;
      end
      else
      begin
         pinMeta <= {writeProtect_n, hold_n, serialIn, serialClock, chipSelect_n};
         pinSync <= pinMeta;
         sclkPrev <= pinSync[1];
      end
   end
   logic csN;
   logic sck;
   logic mosi;
   logic holdN;
   logic wpN;
   assign csN = pinSync[0];
   assign sck = pinSync[1];
   assign mosi = pinSync[2];
   assign holdN = pinSync[3];
   assign wpN = pinSync[4];
   logic sckRise;
   logic sckFall;
   assign sckRise = sck && !sclkPrev;
   assign sckFall = !sck && sclkPrev;
   // ----------------------------------------------------------------
   // select tracking and pause
   // ----------------------------------------------------------------
   logic csPrev;
   logic armed;
   logic selected;
   logic paused;
   logic csFall;
   logic csRise;
   assign csFall = csPrev && !csN;
   assign csRise = !csPrev && csN;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         csPrev <= 1'b0;
         armed <= 1'b0;
         selected <= 1'b0;
      end
      else
      begin
         csPrev <= csN;
         if (csN)
            armed <= 1'b1; // RULE8
         if (csN)
            selected <= 1'b0;
         else if (csFall && armed)
            selected <= 1'b1; // RULE8
      end
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         paused <= 1'b0;
      else if (csN)
         paused <= 1'b0; // RULE7
      else if (!paused && !holdN && !sck)
         paused <= 1'b1; // RULE4
      else if (paused && holdN && !sck)
         paused <= 1'b0; // RULE6
   end
   logic active;
   assign active = selected && !paused; // RULE5
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   spiep_pkg::spiep_state_e state;
   logic [2:0] bitCnt;
   logic [7:0] shiftIn;
   logic [7:0] opcode;
   logic [1:0] addrBytes;
   logic [15:0] addr;
   logic [7:0] shiftOut;
   logic dataSeen;
   logic [7:0] statData;
   logic isWrite;
   logic byteDone;
   logic [7:0] nextByte;
   assign nextByte = {shiftIn[6:0], mosi};
   assign byteDone = active && sckRise && (bitCnt == 3'h7);
   assign isWrite = (opcode == spiep_pkg::CMD_ARR_WR) || (opcode == spiep_pkg::CMD_STAT_WR)
      || (opcode == spiep_pkg::CMD_ID_WR);
   logic busy;
   logic write_enable_latch;
   logic [1:0] bp;
   logic swd;
   logic [7:0] status;
   assign status = {swd, 3'h0, bp, write_enable_latch, busy}; // RULE13
   logic fifoReady;
   logic protectedAddr;
   always_comb
   begin
      protectedAddr = 1'b0;
      if (opcode == spiep_pkg::CMD_ID_WR)
         protectedAddr = (bp == 2'h3); // RULE18
      else
         case (bp)
            spiep_pkg::BP_NONE: protectedAddr = 1'b0;
            spiep_pkg::BP_QTR: protectedAddr = addr[10:0] >= spiep_pkg::ADDR_QTR;
            spiep_pkg::BP_HALF: protectedAddr = addr[10:0] >= spiep_pkg::ADDR_HALF;
            default: protectedAddr = 1'b1;
         endcase
   end
   logic dataPush;
   assign dataPush = byteDone && (state == spiep_pkg::ST_DATA) && (opcode != spiep_pkg::CMD_STAT_WR);
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= spiep_pkg::ST_IDLE;
         bitCnt <= 3'h0;
         shiftIn <= 8'h00;
         opcode <= 8'h00;
         addrBytes <= 2'h0;
         addr <= 16'h0000;
         dataSeen <= 1'b0;
         statData <= 8'h00;
      end
      else if (!selected)
      begin
         state <= spiep_pkg::ST_IDLE; // RULE7
         bitCnt <= 3'h0;
      end
      else if (active && sckRise && fifoReady)
      begin
         bitCnt <= bitCnt + 3'h1;
         shiftIn <= nextByte;
         if (state == spiep_pkg::ST_IDLE)
            state <= spiep_pkg::ST_CMD;
         if (bitCnt == 3'h7)
            case (state)
               spiep_pkg::ST_IDLE, spiep_pkg::ST_CMD:
               begin
                  opcode <= nextByte;
                  dataSeen <= 1'b0;
                  addrBytes <= 2'h0;
                  if ((nextByte == spiep_pkg::CMD_STAT_RD))
                     state <= spiep_pkg::ST_READ;
                  else if (nextByte == spiep_pkg::CMD_STAT_WR)
                     state <= busy ? spiep_pkg::ST_WAIT : spiep_pkg::ST_DATA; // RULE23
                  else if (nextByte == spiep_pkg::CMD_ARR_RD || nextByte == spiep_pkg::CMD_ARR_WR
                     || nextByte == spiep_pkg::CMD_ID_RD || nextByte == spiep_pkg::CMD_ID_WR)
                     state <= busy ? spiep_pkg::ST_WAIT : spiep_pkg::ST_ADDR;
                  else
                     state <= spiep_pkg::ST_WAIT;
               end
               spiep_pkg::ST_ADDR:
               begin
                  addr <= {addr[7:0], nextByte};
                  addrBytes <= addrBytes + 2'h1;
                  if (addrBytes == 2'h1)
                     state <= isWrite ? spiep_pkg::ST_DATA : spiep_pkg::ST_READ; // RULE10
               end
               spiep_pkg::ST_DATA:
               begin
                  dataSeen <= 1'b1;
                  statData <= nextByte;
               end
               spiep_pkg::ST_READ:
                  addr <= addr + 16'h0001; // RULE12
               default: state <= spiep_pkg::ST_WAIT;
            endcase
      end
   end
   // ----------------------------------------------------------------
   // write buffer
   // ----------------------------------------------------------------
   logic fifoFlush;
   logic commitAccept;
   // refused writes must not leave their bytes behind for the next accepted one
   assign fifoFlush = csRise && !commitAccept;
   spiep_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(fifoFlush),
      .inValid(dataPush),
      .inReady(fifoReady),
      .inData(nextByte),
      .outValid(memWrValid),
      .outReady(memWrReady && busy),
      .outData(memWrData)
   );
   // ----------------------------------------------------------------
   // execute on deselect, status and write cycle
   // ----------------------------------------------------------------
   logic commitOk;
   logic srFrozen;
   logic [$clog2(WRITE_CYCLES+1)-1:0] cycleCnt;
   assign srFrozen = swd && !wpN; // RULE20 RULE21
   assign commitOk = csRise && selected && write_enable_latch && (state == spiep_pkg::ST_DATA)
      && dataSeen && (bitCnt == 3'h0); // RULE9 RULE10 RULE11 RULE15
   assign commitAccept = commitOk && !busy && !protectedAddr && (opcode != spiep_pkg::CMD_STAT_WR);
   // latch opcodes always end in the wait state, busy or not
   logic latchOp;
   assign latchOp = csRise && selected && (state == spiep_pkg::ST_WAIT) && (bitCnt == 3'h0);
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy <= 1'b0;
         write_enable_latch <= 1'b0; // RULE16
         bp <= spiep_pkg::BP_RESET[1:0];
         swd <= 1'b0;
         cycleCnt <= '0;
         memCommit <= 1'b0;
      end
      else
      begin
         memCommit <= 1'b0;
         if (latchOp)
         begin
            if (opcode == spiep_pkg::CMD_SET_WEN)
               write_enable_latch <= 1'b1; // RULE16
            else if (opcode == spiep_pkg::CMD_CLR_WEN)
               write_enable_latch <= 1'b0; // RULE16
         end
         if (commitOk && !busy)
         begin
            busy <= 1'b1; // RULE14
            cycleCnt <= '0;
            if (opcode == spiep_pkg::CMD_STAT_WR && !srFrozen)
            begin
               swd <= statData[spiep_pkg::BIT_SWD]; // RULE17 RULE19
               bp <= statData[spiep_pkg::BIT_BPHI:spiep_pkg::BIT_BPLO];
            end
            else if (opcode != spiep_pkg::CMD_STAT_WR && !protectedAddr)
               memCommit <= 1'b1; // RULE18
         end
         else if (busy)
         begin
            if (cycleCnt == $bits(cycleCnt)'(WRITE_CYCLES - 1))
            begin
               busy <= 1'b0; // RULE14
               // a set-enable landing on the last cycle wins over the clear
               if (!(latchOp && opcode == spiep_pkg::CMD_SET_WEN))
                  write_enable_latch <= 1'b0; // RULE16
            end
            else
               cycleCnt <= cycleCnt + 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // serial output
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shiftOut <= 8'h00;
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end
      else
      begin
         serialOutEn <= active && (state == spiep_pkg::ST_READ); // RULE5 RULE22
         if (active && sckFall && state == spiep_pkg::ST_READ) // RULE2
         begin
            if (bitCnt == 3'h0)
            begin
               shiftOut <= (opcode == spiep_pkg::CMD_STAT_RD) ? {status[6:0], 1'b0}
                  : {memRdData[6:0], 1'b0};
               serialOut <= (opcode == spiep_pkg::CMD_STAT_RD) ? status[7] : memRdData[7]; // RULE22
            end
            else
            begin
               serialOut <= shiftOut[7];
               shiftOut <= {shiftOut[6:0], 1'b0};
            end
         end
      end
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         standby <= 1'b1;
         statusProtectionRegister <= 8'h00;
         memAddr <= 16'h0000;
         memIdPage <= 1'b0;
      end
      else
      begin
         standby <= !selected && !busy; // RULE1
         statusProtectionRegister <= status;
         memAddr <= addr;
         memIdPage <= opcode[7];
      end
   end
endmodule : spiep_front
`default_nettype wire

// ===== rtl/spiep_pkg.sv
package spiep_pkg;
   // status bit positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_BPLO = 2;
   localparam int BIT_BPHI = 3;
   localparam int BIT_SWD = 7;
   // opcodes
   localparam logic [7:0] CMD_SET_WEN = 8'h06;
   localparam logic [7:0] CMD_CLR_WEN = 8'h04;
   localparam logic [7:0] CMD_STAT_RD = 8'h05;
   localparam logic [7:0] CMD_STAT_WR = 8'h01;
   localparam logic [7:0] CMD_ARR_RD = 8'h03;
   localparam logic [7:0] CMD_ARR_WR = 8'h02;
   localparam logic [7:0] CMD_ID_RD = 8'h83;
   localparam logic [7:0] CMD_ID_WR = 8'h82;
   // address limits of the protected areas
   localparam logic [10:0] ADDR_QTR = 11'h600;
   localparam logic [10:0] ADDR_HALF = 11'h400;
   localparam logic [15:0] ADDR_LOCK = 16'h0400;
   // write cycle
   localparam int WRITE_CYCLE_NS = 4000000;
   localparam int CLK_NS = 10;
   localparam int WRITE_CYCLES = WRITE_CYCLE_NS / CLK_NS;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QTR = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [7:0] BP_RESET = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD = 3'h1,
      ST_ADDR = 3'h3,
      ST_DATA = 3'h2,
      ST_READ = 3'h6,
      ST_WAIT = 3'h7
   } spiep_state_e;
endpackage : spiep_pkg

// ===== tb/spiep_front_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module spiep_front_asserts #(
   parameter int WRITE_CYCLES = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // watched pins and state
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic hold_n,
   input wire logic serialOutEn,
   input wire logic memCommit,
   input wire logic standby,
   input wire logic [7:0] statusProtectionRegister
);
   wire logic busy = statusProtectionRegister[0];
   wire logic [2:0] prot = {statusProtectionRegister[7], statusProtectionRegister[3:2]};
   logic [31:0] busyLen;
   // length of the current busy stretch
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         busyLen <= '0;
      else
         busyLen <= busy ? busyLen + 32'h1 : '0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_act;
      $fell(chipSelect_n) |-> ##[1:5] !standby;
   endproperty
   a_act: assert property (p_act) else $error("standby while selected");
   property p_off;
      chipSelect_n [*6] |-> !serialOutEn;
   endproperty
   a_off: assert property (p_off) else $error("output driven while deselected");
   property p_hold;
      (!hold_n && !serialClock) [*6] |-> !serialOutEn;
   endproperty
   a_hold: assert property (p_hold) else $error("output driven while paused");
   property p_zero;
      statusProtectionRegister[6:4] == 3'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("unused status bits set");
   property p_start;
      $rose(busy) |-> chipSelect_n && statusProtectionRegister[1];
   endproperty
   a_start: assert property (p_start) else $error("write began without latch");
   property p_len;
      $fell(busy) |-> busyLen == WRITE_CYCLES;
   endproperty
   a_len: assert property (p_len) else $error("write cycle length wrong");
   property p_wel;
      $fell(busy) |-> ##[0:1] !statusProtectionRegister[1];
   endproperty
   a_wel: assert property (p_wel) else $error("latch kept after write");
   property p_prot;
      !$stable(prot) |-> busy || $past(busy);
   endproperty
   a_prot: assert property (p_prot) else $error("protect bits moved outside write");
   property p_commit;
      memCommit |=> busy && chipSelect_n;
   endproperty
   a_commit: assert property (p_commit) else $error("commit outside write");
endmodule : spiep_front_asserts
`default_nettype wire

// ===== tb/spiep_front_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spiep_front_tb;
   localparam int WRITE_CYCLES = 400;
   logic clk;
   logic reset_n = 1'b0;
   logic writeProtect_n = 1'b1;
   logic memWrReady = 1'b0;
   logic [7:0] memRdData = 8'h00;
   logic flip = 1'b0;
   logic [7:0] rx;
   int commits = 0;
   int err_count = 0;
   int comparisons = 0;
   wire logic chipSelect_n, serialClock, serialIn, hold_n, serialOut, serialOutEn;
   wire logic memWrValid, memIdPage, memCommit, standby;
   wire logic [7:0] memWrData, statusProtectionRegister;
   wire logic [15:0] memAddr;
   // floating output line toggles so it never reads as data
   wire logic line = serialOutEn ? serialOut : flip;
   initial
   begin
      clk = 1'b0;
      forever
         #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      flip <= ~flip;
      memRdData <= memAddr[7:0];
      if (memCommit === 1'b1)
         commits <= commits + 1;
   end
   spiep_front #(.WRITE_CYCLES(WRITE_CYCLES)) i_spiep_front (
      .clk, .reset_n, .chipSelect_n, .serialClock, .serialIn, .hold_n, .writeProtect_n,
      .serialOut, .serialOutEn, .memWrValid, .memWrReady, .memWrData, .memAddr,
      .memIdPage, .memCommit, .memRdData, .standby, .statusProtectionRegister
   );
   spiep_mst i_spiep_mst (
      .clk, .serialOut(line), .chipSelect_n, .serialClock, .serialIn, .hold_n
   );
   task automatic summarize();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask : tk
   task automatic wen();
      i_spiep_mst.cmd(spiep_pkg::CMD_SET_WEN, 8'h00, 0);
   endtask : wen
   task automatic settle();
      tk(10);
      for (int i = 0; i < 1000 && statusProtectionRegister[0] !== 1'b0; i++)
         tk(1);
   endtask : settle
   task automatic rdst(input logic [7:0] exp);
      i_spiep_mst.sel();
      i_spiep_mst.bits(spiep_pkg::CMD_STAT_RD, 8, rx);
      repeat (2)
      begin
         i_spiep_mst.bits(8'h00, 8, rx);
         chk(rx, exp);
      end
      i_spiep_mst.desel();
   endtask : rdst
   // select already low when power comes up
   task automatic t_powerup();
      i_spiep_mst.cs(1'b0);
      tk(2);
      reset_n <= 1'b0;
      tk(3);
      reset_n <= 1'b1;
      tk(5);
      i_spiep_mst.bits(spiep_pkg::CMD_SET_WEN, 8, rx);
      i_spiep_mst.desel();
      chk(statusProtectionRegister, 8'h00);
   endtask : t_powerup
   task automatic t_modes();
      for (int m = 0; m < 2; m++)
      begin
         i_spiep_mst.cpol = m[0];
         wen();
         rdst(8'h02);
         i_spiep_mst.cmd(spiep_pkg::CMD_CLR_WEN, 8'h00, 0);
         rdst(8'h00);
      end
      i_spiep_mst.cpol = 1'b0;
   endtask : t_modes
   task automatic t_status();
      i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, 8'hFF, 8);
      settle();
      chk(statusProtectionRegister, 8'h00);
      wen();
      i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, 8'hFF, 3);
      i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, 8'hFF, 0);
      settle();
      chk(statusProtectionRegister, 8'h02);
      i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, 8'hFF, 8);
      chk(statusProtectionRegister & 8'h03, 8'h03);
      chk({7'h00, standby}, 8'h00);
      i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, 8'h00, 8);
      settle();
      chk(statusProtectionRegister, 8'h8C);
   endtask : t_status
   // entries: pin level, written value, expected protect bits
   task automatic t_protect();
      logic [23:0] tab [5] = '{24'h00008C, 24'h010404, 24'h008484, 24'h000084, 24'h010404};
      foreach (tab[i])
      begin
         writeProtect_n <= tab[i][16];
         wen();
         i_spiep_mst.cmd(spiep_pkg::CMD_STAT_WR, tab[i][15:8], 8);
         settle();
         chk(statusProtectionRegister & 8'h8C, tab[i][7:0]);
      end
   endtask : t_protect
   // upper quarter protected: first write refused, second one drains with a stall
   task automatic t_array();
      for (int i = 0; i < 2; i++)
      begin
         settle();
         wen();
         i_spiep_mst.sel();
         i_spiep_mst.bits(spiep_pkg::CMD_ARR_WR, 8, rx);
         i_spiep_mst.bits(i ? 8'h01 : 8'h07, 8, rx);
         i_spiep_mst.bits(8'h20, 8, rx);
         i_spiep_mst.bits(8'h5A, 8, rx);
         i_spiep_mst.bits(8'hC3, 8, rx);
         i_spiep_mst.desel();
      end
      chk(commits[7:0], 8'h01);
      chk(memAddr[7:0], 8'h20);
      chk({memWrValid, memIdPage, 6'h00}, 8'h80);
      chk(memWrData, 8'h5A);
      memWrReady <= 1'b1;
      tk(1);
      #1;
      chk(memWrData, 8'hC3);
      tk(1);
      #1;
      chk({7'h00, memWrValid}, 8'h00);
      settle();
   endtask : t_array
   task automatic t_hold();
      i_spiep_mst.sel();
      i_spiep_mst.bits(spiep_pkg::CMD_STAT_RD, 8, rx);
      i_spiep_mst.hold(1'b0);
      tk(12);
      chk({7'h00, serialOutEn}, 8'h00);
      i_spiep_mst.hold(1'b1);
      tk(4);
      i_spiep_mst.bits(8'h00, 8, rx);
      chk(rx, 8'h04);
      i_spiep_mst.hold(1'b0);
      tk(8);
      i_spiep_mst.desel();
      i_spiep_mst.hold(1'b1);
      rdst(8'h04);
   endtask : t_hold
   initial
   begin
      tk(20);
      reset_n <= 1'b1;
      tk(5);
      chk(statusProtectionRegister, 8'h00);
      chk({6'h00, standby, serialOutEn}, 8'h02);
      t_powerup();
      t_modes();
      t_status();
      t_protect();
      t_array();
      t_hold();
      summarize();
   end
   initial
   begin
      tk(60000);
      err_count++;
      summarize();
   end
endmodule : spiep_front_tb
bind spiep_front spiep_front_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_spiep_front_asserts (
   .clk, .reset_n, .chipSelect_n, .serialClock, .hold_n, .serialOutEn, .memCommit,
   .standby, .statusProtectionRegister
);
`default_nettype wire

// ===== tb/spiep_mst.sv
`timescale 1ns/1ps
`default_nettype none
module spiep_mst (
   // clock
   input wire logic clk,
   // spi lines
   input wire logic serialOut,
   output logic chipSelect_n,
   output logic serialClock,
   output logic serialIn,
   output logic hold_n
);
   logic cpol = 1'b0;
   logic odd = 1'b0;
   initial
   begin
      chipSelect_n = 1'b1;
      serialClock = 1'b0;
      serialIn = 1'b0;
      hold_n = 1'b1;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask : tk
   task automatic cs(input logic v);
      chipSelect_n <= v;
   endtask : cs
   // only called while the clock is parked low
   task automatic hold(input logic v);
      hold_n <= v;
   endtask : hold
   task automatic sel();
      serialClock <= cpol;
      tk(4);
      chipSelect_n <= 1'b0;
      tk(4);
   endtask : sel
   // a released data line shows the inverse of its last bit
   task automatic desel();
      tk(3);
      chipSelect_n <= 1'b1;
      serialIn <= ~serialIn;
      tk(8);
   endtask : desel
   // msb first; periods of 12 and 13 clk give 125 ns on average
   task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         if (cpol)
            serialClock <= 1'b0;
         serialIn <= tx[i];
         tk(6);
         serialClock <= 1'b1;
         rx[i] = serialOut;
         tk(6 + int'(odd));
         odd = ~odd;
         if (!cpol)
            serialClock <= 1'b0;
      end
   endtask : bits
   task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int n);
      logic [7:0] rx;
      sel();
      bits(c, 8, rx);
      if (n > 0)
         bits(d, n, rx);
      desel();
   endtask : cmd
endmodule : spiep_mst
`default_nettype wire
